// >>> pkg/qudsp_pkg.sv
package qudsp_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int QUDSP_AW = 8;
	localparam logic [7:0] QUDSP_CTRL_OFF = 8'h00;
	localparam logic [7:0] QUDSP_CTRL2_OFF = 8'h04;
	localparam logic [7:0] QUDSP_RATE_OFF = 8'h08;
	localparam logic [7:0] QUDSP_PSEL_OFF = 8'h0C;
	localparam logic [7:0] QUDSP_STAT_OFF = 8'h10;
	localparam logic [7:0] QUDSP_PHASE_OFF = 8'h14;
	// eight profiles of 16 bytes each: +0 tuning, +4 phase/amplitude, +8 gain/invert
	localparam logic [7:0] QUDSP_PROF_BASE = 8'h80;
	localparam logic [1:0] QUDSP_PW_TUNE = 2'h0;
	localparam logic [1:0] QUDSP_PW_PHAMP = 2'h1;
	localparam logic [1:0] QUDSP_PW_GAIN = 2'h2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int QUDSP_CTRL_MODE_LSB = 0;
	localparam int QUDSP_CTRL_INVSINC_BIT = 2;
	localparam int QUDSP_CTRL_SINESEL_BIT = 3;
	localparam int QUDSP_CTRL2_AMPBYP_BIT = 24;
	localparam int QUDSP_PROF_POW_LSB = 0;
	localparam int QUDSP_PROF_ASF_LSB = 16;
	localparam int QUDSP_PROF_GAIN_LSB = 0;
	localparam int QUDSP_PROF_INV_BIT = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] QUDSP_RATE_RST = 6'h02;
	localparam logic [31:0] QUDSP_TUNE_RST = 32'h00000000;
	localparam logic [13:0] QUDSP_POW_RST = 14'h0000;
	localparam logic [13:0] QUDSP_ASF_RST = 14'h3FFF;
	localparam logic [7:0] QUDSP_GAIN_UNITY = 8'h80;

	// ----------------------------------------------------------------
	// datapath constants
	// ----------------------------------------------------------------
	localparam logic signed [15:0] QUDSP_SINC_C1 = -16'sd35;
	localparam logic signed [15:0] QUDSP_SINC_C2 = 16'sd134;
	localparam logic signed [15:0] QUDSP_SINC_C3 = -16'sd562;
	localparam logic signed [15:0] QUDSP_SINC_C4 = 16'sd6729;
	localparam int QUDSP_SINC_SHIFT = 13;
	localparam int QUDSP_CIC_ORDER = 5;
	localparam int QUDSP_CORDIC_STAGES = 14;
	// 0.60725 * 2^16, pre-compensates the rotation gain
	localparam logic signed [17:0] QUDSP_CORDIC_X0 = 18'sh09B75;

	typedef enum logic [1:0] {
		QUDSP_MODE_QUAD,
		QUDSP_MODE_IDAC,
		QUDSP_MODE_TONE
	} qudsp_mode_t;

endpackage

// >>> rtl/qudsp_chain.sv
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module qudsp_chain
	import qudsp_pkg::*;
#(
	parameter int DW = 18,
	parameter int CW = 48,
	parameter int NPROF = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [QUDSP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [DW-1:0] bb_i,
	input wire logic signed [DW-1:0] bb_q,
	output logic bb_ready,
	output logic signed [13:0] dac_data
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] cic_shift(input logic [5:0] r);
		logic [23:0] p;
		logic [5:0] s;
		p = 24'(r) * 24'(r) * 24'(r) * 24'(r);
		s = 6'h00;
		for (int k = 0; k < 24; k++) begin
			if ((24'h000001 << k) < p) begin
				s = 6'(k + 1);
			end
		end
		return s;
	endfunction

	function automatic logic signed [17:0] atan_lut(input int k);
		logic signed [17:0] v;
		case (k)
			0: v = 18'sd8192;
			1: v = 18'sd4836;
			2: v = 18'sd2555;
			3: v = 18'sd1297;
			4: v = 18'sd651;
			5: v = 18'sd326;
			6: v = 18'sd163;
			7: v = 18'sd81;
			8: v = 18'sd41;
			9: v = 18'sd20;
			10: v = 18'sd10;
			11: v = 18'sd5;
			12: v = 18'sd3;
			default: v = 18'sd1;
		endcase
		return v;
	endfunction

	function automatic logic signed [DW-1:0] sat_dw(input logic signed [CW-1:0] v);
		logic signed [CW-1:0] hi;
		logic signed [CW-1:0] lo;
		hi = CW'((64'sd1 <<< (DW - 1)) - 64'sd1);
		lo = -hi - CW'(1);
		if (v > hi) begin
			return hi[DW-1:0];
		end else if (v < lo) begin
			return lo[DW-1:0];
		end
		return v[DW-1:0];
	endfunction

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [1:0] mode_bits_r;
	logic invsinc_en_r;
	logic sine_sel_r;
	logic amp_bypass_r;
	logic [5:0] rate_r;
	logic [2:0] prof_sel_r;
	logic [31:0] tuning_word_r [NPROF];
	logic [13:0] phase_offset_word_r [NPROF];
	logic [13:0] amplitude_scale_r [NPROF];
	logic [7:0] output_gain_r [NPROF];
	logic invert_r [NPROF];
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] phase_acc_r;

	qudsp_mode_t mode;
	assign mode = qudsp_mode_t'(mode_bits_r);

	// ----------------------------------------------------------------
	// apb slave: zero wait states, data latched in the setup cycle
	// ----------------------------------------------------------------
	wire in_prof = paddr[7];
	wire [2:0] p_idx = paddr[6:4];
	wire [1:0] p_word = paddr[3:2];
	wire hit_ctrl = paddr == QUDSP_CTRL_OFF;
	wire hit_ctrl2 = paddr == QUDSP_CTRL2_OFF;
	wire hit_rate = paddr == QUDSP_RATE_OFF;
	wire hit_psel = paddr == QUDSP_PSEL_OFF;
	wire hit_stat = paddr == QUDSP_STAT_OFF;
	wire hit_phase = paddr == QUDSP_PHASE_OFF;
	wire hit_prof = in_prof && paddr[1:0] == 2'h0 && p_word != 2'h3;
	wire mapped = hit_ctrl || hit_ctrl2 || hit_rate || hit_psel || hit_stat || hit_phase || hit_prof;
	wire setup = psel && !penable;
	wire wr_en = psel && penable && pwrite && mapped;
	wire [31:0] rd_prof =
		p_word == QUDSP_PW_TUNE ? tuning_word_r[p_idx] :
		p_word == QUDSP_PW_PHAMP ? {2'h0, amplitude_scale_r[p_idx], 2'h0, phase_offset_word_r[p_idx]} :
		{23'h000000, invert_r[p_idx], output_gain_r[p_idx]};
	wire [31:0] rd_mux =
		hit_ctrl ? {28'h0000000, sine_sel_r, invsinc_en_r, mode_bits_r} :
		hit_ctrl2 ? {7'h00, amp_bypass_r, 24'h000000} :
		hit_rate ? {26'h0000000, rate_r} :
		hit_psel ? {29'h00000000, prof_sel_r} :
		hit_stat ? {14'h0000, 2'(mode), 2'h0, dac_data} :
		hit_phase ? phase_acc_r :
		hit_prof ? rd_prof : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= 1'b1;
			if (setup) begin
				prdata_r <= rd_mux;
				pslverr_r <= !mapped;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_bits_r <= 2'h0;
			invsinc_en_r <= 1'b0;
			sine_sel_r <= 1'b0;
			amp_bypass_r <= 1'b0;
			rate_r <= QUDSP_RATE_RST;
			prof_sel_r <= 3'h0;
			for (int p = 0; p < NPROF; p++) begin
				tuning_word_r[p] <= QUDSP_TUNE_RST;
				phase_offset_word_r[p] <= QUDSP_POW_RST;
				amplitude_scale_r[p] <= QUDSP_ASF_RST;
				output_gain_r[p] <= QUDSP_GAIN_UNITY;
				invert_r[p] <= 1'b0;
			end
		end else if (wr_en) begin
			if (hit_ctrl) begin
				mode_bits_r <= pwdata[QUDSP_CTRL_MODE_LSB +: 2];
				invsinc_en_r <= pwdata[QUDSP_CTRL_INVSINC_BIT];
				sine_sel_r <= pwdata[QUDSP_CTRL_SINESEL_BIT];
			end
			if (hit_ctrl2) begin
				amp_bypass_r <= pwdata[QUDSP_CTRL2_AMPBYP_BIT];
			end
			if (hit_rate) begin
				rate_r <= pwdata[5:0];
			end
			if (hit_psel) begin
				prof_sel_r <= pwdata[2:0];
			end
			if (hit_prof && p_word == QUDSP_PW_TUNE) begin
				tuning_word_r[p_idx] <= pwdata;
			end
			if (hit_prof && p_word == QUDSP_PW_PHAMP) begin
				phase_offset_word_r[p_idx] <= pwdata[QUDSP_PROF_POW_LSB +: 14];
				amplitude_scale_r[p_idx] <= pwdata[QUDSP_PROF_ASF_LSB +: 14];
			end
			if (hit_prof && p_word == QUDSP_PW_GAIN) begin
				output_gain_r[p_idx] <= pwdata[QUDSP_PROF_GAIN_LSB +: 8];
				invert_r[p_idx] <= pwdata[QUDSP_PROF_INV_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// comb-integrator interpolator
	// ----------------------------------------------------------------
	// rates 0 and 1 both bypass; integrators are held at zero to idle the stage
	wire cic_bypass = rate_r <= 6'h01;
	logic [5:0] rate_cnt_r;
	logic bb_ready_r;
	logic [5:0] shift_r;
	logic signed [CW-1:0] comb_dly_r [2][QUDSP_CIC_ORDER];
	logic signed [CW-1:0] integ_r [2][QUDSP_CIC_ORDER];
	logic signed [CW-1:0] comb_v [2][QUDSP_CIC_ORDER+1];
	logic signed [DW-1:0] base_r [2];

	// one input pair per R clocks, paced by bb_ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_cnt_r <= 6'h00;
			bb_ready_r <= 1'b0;
			shift_r <= 6'h00;
		end else begin
			shift_r <= cic_shift(rate_r);
			rate_cnt_r <= (cic_bypass || rate_cnt_r >= rate_r - 6'h01) ? 6'h00 : rate_cnt_r + 6'h01;
			bb_ready_r <= cic_bypass || rate_cnt_r >= rate_r - 6'h01;
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			comb_v[c][0] = CW'(c == 0 ? bb_i : bb_q);
			for (int k = 0; k < QUDSP_CIC_ORDER; k++) begin
				comb_v[c][k+1] = comb_v[c][k] - comb_dly_r[c][k];
			end
		end
	end

	// same structure on both channels keeps I and Q aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < 2; c++) begin
				base_r[c] <= '0;
				for (int k = 0; k < QUDSP_CIC_ORDER; k++) begin
					comb_dly_r[c][k] <= '0;
					integ_r[c][k] <= '0;
				end
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				for (int k = 0; k < QUDSP_CIC_ORDER; k++) begin
					if (bb_ready_r) begin
						comb_dly_r[c][k] <= cic_bypass ? '0 : comb_v[c][k];
					end
					if (k == 0) begin
						integ_r[c][k] <= cic_bypass ? '0 : integ_r[c][k] + (bb_ready_r ? comb_v[c][QUDSP_CIC_ORDER] : '0);
					end else begin
						integ_r[c][k] <= cic_bypass ? '0 : integ_r[c][k] + integ_r[c][k-1];
					end
				end
				if (cic_bypass) begin
					base_r[c] <= c == 0 ? bb_i : bb_q;
				end else begin
					base_r[c] <= sat_dw(integ_r[c][QUDSP_CIC_ORDER-1] >>> shift_r);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// carrier synthesizer
	// ----------------------------------------------------------------
	logic signed [17:0] cx_r [QUDSP_CORDIC_STAGES+1];
	logic signed [17:0] cy_r [QUDSP_CORDIC_STAGES+1];
	logic signed [17:0] cz_r [QUDSP_CORDIC_STAGES+1];
	wire [15:0] phase_word = phase_acc_r[31:16] + {phase_offset_word_r[prof_sel_r], 2'b00};
	wire phase_flip = phase_word[15] ^ phase_word[14];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_acc_r <= 32'h00000000;
			for (int k = 0; k <= QUDSP_CORDIC_STAGES; k++) begin
				cx_r[k] <= '0;
				cy_r[k] <= '0;
				cz_r[k] <= '0;
			end
		end else begin
			phase_acc_r <= phase_acc_r + tuning_word_r[prof_sel_r];
			// fold the outer half turn so the rotation stays within convergence
			cx_r[0] <= phase_flip ? -QUDSP_CORDIC_X0 : QUDSP_CORDIC_X0;
			cy_r[0] <= '0;
			cz_r[0] <= 18'(signed'(phase_flip ? phase_word - 16'h8000 : phase_word));
			for (int k = 0; k < QUDSP_CORDIC_STAGES; k++) begin
				if (cz_r[k][17]) begin
					cx_r[k+1] <= cx_r[k] + (cy_r[k] >>> k);
					cy_r[k+1] <= cy_r[k] - (cx_r[k] >>> k);
					cz_r[k+1] <= cz_r[k] + atan_lut(k);
				end else begin
					cx_r[k+1] <= cx_r[k] - (cy_r[k] >>> k);
					cy_r[k+1] <= cy_r[k] + (cx_r[k] >>> k);
					cz_r[k+1] <= cz_r[k] - atan_lut(k);
				end
			end
		end
	end

	wire signed [17:0] carrier_cos = cx_r[QUDSP_CORDIC_STAGES];
	wire signed [17:0] carrier_sin = cy_r[QUDSP_CORDIC_STAGES];

	// ----------------------------------------------------------------
	// modulator, tone amplitude, mode select
	// ----------------------------------------------------------------
	logic signed [35:0] prod_i_r;
	logic signed [35:0] prod_q_r;
	logic signed [31:0] amp_prod_r;
	logic signed [DW-1:0] tone_r;
	logic signed [DW-1:0] idac_r;
	logic signed [DW-1:0] stage_r;
	wire inv_act = invert_r[prof_sel_r];
	wire signed [17:0] tone_pick = sine_sel_r ? carrier_sin : carrier_cos;
	wire signed [14:0] amp_act = $signed({1'b0, amplitude_scale_r[prof_sel_r]});
	wire signed [36:0] mod_sum = inv_act ? 37'(prod_i_r) + 37'(prod_q_r) : 37'(prod_i_r) - 37'(prod_q_r);
	wire signed [CW-1:0] mod_scaled = CW'(mod_sum >>> 16);
	wire signed [CW-1:0] amp_scaled = CW'(amp_prod_r >>> 14);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prod_i_r <= '0;
			prod_q_r <= '0;
			amp_prod_r <= '0;
			tone_r <= '0;
			idac_r <= '0;
			stage_r <= '0;
		end else begin
			prod_i_r <= 36'(base_r[0]) * 36'(carrier_cos);
			prod_q_r <= 36'(base_r[1]) * 36'(carrier_sin);
			// the product register freezes while bypassed so the multiplier idles
			amp_prod_r <= amp_bypass_r ? amp_prod_r : 32'(tone_pick) * 32'(amp_act);
			tone_r <= amp_bypass_r ? tone_pick : sat_dw(amp_scaled);
			idac_r <= base_r[0];
			unique case (mode)
				QUDSP_MODE_QUAD: stage_r <= sat_dw(mod_scaled);
				QUDSP_MODE_IDAC: stage_r <= idac_r;
				QUDSP_MODE_TONE: stage_r <= tone_r;
				default: stage_r <= sat_dw(mod_scaled);
			endcase
		end
	end

	// ----------------------------------------------------------------
	// output gain, inverse sinc, converter word
	// ----------------------------------------------------------------
	logic signed [DW-1:0] gain_r;
	logic signed [DW-1:0] tap_r [7];
	logic signed [13:0] dac_r;
	wire [7:0] gain_act = output_gain_r[prof_sel_r];
	wire gain_on = mode != QUDSP_MODE_TONE && gain_act != QUDSP_GAIN_UNITY;
	wire signed [CW-1:0] gain_prod = (CW'(stage_r) * CW'($signed({1'b0, gain_act}))) >>> 7;
	wire signed [CW-1:0] fir_sum =
		CW'(QUDSP_SINC_C1) * (CW'(tap_r[0]) + CW'(tap_r[6])) +
		CW'(QUDSP_SINC_C2) * (CW'(tap_r[1]) + CW'(tap_r[5])) +
		CW'(QUDSP_SINC_C3) * (CW'(tap_r[2]) + CW'(tap_r[4])) +
		CW'(QUDSP_SINC_C4) * CW'(tap_r[3]);
	wire signed [DW-1:0] fir_out = sat_dw(fir_sum >>> QUDSP_SINC_SHIFT);
	wire signed [DW-1:0] final_v = invsinc_en_r ? fir_out : tap_r[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_r <= '0;
			dac_r <= '0;
			for (int k = 0; k < 7; k++) begin
				tap_r[k] <= '0;
			end
		end else begin
			gain_r <= gain_on ? sat_dw(gain_prod) : stage_r;
			tap_r[0] <= gain_r;
			for (int k = 1; k < 7; k++) begin
				tap_r[k] <= tap_r[k-1];
			end
			dac_r <= final_v[DW-1 -: 14];
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign bb_ready = bb_ready_r;
	assign dac_data = dac_r;

endmodule // qudsp_chain

// >>> sim/qudsp_checker.sv
`timescale 1ns/100ps
module qudsp_checker
	import qudsp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [QUDSP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bb_ready,
	input wire logic signed [13:0] dac_data
);
	// ----------------------------------------------------------------
	// shadow of the rate word and pulse spacing
	// ----------------------------------------------------------------
	logic [5:0] rate_r;
	logic [1:0] armed_r;
	logic [6:0] gap_r;
	wire acc = psel && penable;
	wire wr_rate = acc && pwrite && paddr == QUDSP_RATE_OFF;
	wire aligned = paddr[1:0] == 2'h0;
	wire mapped = paddr < 8'h18 || (paddr[7] && paddr[3:2] != 2'h3);
	// the first gap after a rate change may be irregular, so wait two pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_r <= QUDSP_RATE_RST;
			armed_r <= 2'h0;
			gap_r <= 7'h00;
		end else begin
			rate_r <= wr_rate ? pwdata[5:0] : rate_r;
			armed_r <= wr_rate ? 2'h0 : (bb_ready && armed_r != 2'h2) ? armed_r + 2'h1 : armed_r;
			gap_r <= bb_ready ? 7'h00 : (gap_r == 7'h7F) ? gap_r : gap_r + 7'h01;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_access: assert property (acc |-> pready) else $error("pready low in access phase");
	a_unmapped_err: assert property (acc && aligned |-> pslverr == !mapped) else $error("pslverr wrong");
	a_unmapped_zero: assert property (acc && !pwrite && aligned && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (acc |=> $stable(prdata)) else $error("prdata moved after access");
	a_rate_readback: assert property (acc && !pwrite && paddr == QUDSP_RATE_OFF |-> prdata[5:0] == rate_r)
		else $error("rate readback wrong");
	a_pulse_period: assert property (bb_ready && armed_r == 2'h2 && rate_r >= 6'h02
		|-> gap_r == 7'(rate_r - 6'h01)) else $error("input pulse spacing wrong");
	a_pulse_single: assert property (bb_ready && armed_r == 2'h2 && rate_r >= 6'h02 |=> !bb_ready)
		else $error("input pulse too long");
	a_held_bypass: assert property (armed_r == 2'h2 && rate_r <= 6'h01 |-> bb_ready [*2])
		else $error("bypass input not held");
	a_status_dac: assert property (psel && !penable && !pwrite && paddr == QUDSP_STAT_OFF
		|=> prdata[13:0] == $past(dac_data)) else $error("status not current sample");
	c_rate_one: cover property (wr_rate && pwdata[5:0] == 6'h01);
	c_slverr: cover property (acc && pslverr);
	c_rate_max: cover property (bb_ready && armed_r == 2'h2 && rate_r == 6'h3F);
endmodule // qudsp_checker

bind qudsp_chain qudsp_checker i_qudsp_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.bb_ready(bb_ready), .dac_data(dac_data));

// >>> sim/qudsp_partner.sv
`timescale 1ns/100ps
module qudsp_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bb_ready,
	input wire logic signed [17:0] i_val,
	input wire logic signed [17:0] q_val,
	output logic signed [17:0] bb_i,
	output logic signed [17:0] bb_q,
	input wire logic signed [13:0] dac_data,
	output logic signed [13:0] dac_seen
);
	// outside the take cycle the source shows the inverse, so a late sample shows up
	assign bb_i = bb_ready ? i_val : ~i_val;
	assign bb_q = bb_ready ? q_val : ~q_val;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_seen <= 14'sh0000;
		end else begin
			dac_seen <= dac_data;
		end
	end
endmodule // qudsp_partner

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
	import qudsp_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic bb_ready;
	logic signed [17:0] bb_i;
	logic signed [17:0] bb_q;
	logic signed [17:0] i_val = 18'sh00000;
	logic signed [17:0] q_val = 18'sh00000;
	logic signed [13:0] dac_data;
	logic signed [13:0] dac_seen;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int at_cyc;
	int c0;
	logic [31:0] rd;
	logic [31:0] p0;
	logic err;
	int tp[3] = '{0, 0, 5};
	logic [31:0] tw[3] = '{32'h01234567, 32'h7FFFFFFF, 32'h00ABCDEF};
	int gs[3] = '{64, 192, 0};
	initial begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	qudsp_chain i_qudsp_chain (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bb_i(bb_i),
		.bb_q(bb_q), .bb_ready(bb_ready), .dac_data(dac_data));
	qudsp_partner i_qudsp_partner (.pclk(pclk), .presetn(presetn), .bb_ready(bb_ready), .i_val(i_val),
		.q_val(q_val), .bb_i(bb_i), .bb_q(bb_q), .dac_data(dac_data), .dac_seen(dac_seen));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		at_cyc = cyc;
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [7:0] pa(input int p, input logic [1:0] w);
		return QUDSP_PROF_BASE + 8'(p * 16) + {4'h0, w, 2'b00};
	endfunction
	// settling covers interpolator, carrier and tap pipelines
	task automatic near(input int exp);
		int d;
		repeat (300) @(posedge pclk);
		d = int'(dac_seen) - exp;
		check({31'h0, !$isunknown(dac_seen) && d <= 12 && d >= -12}, 32'h1);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		miscompares++;
		close_out();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, QUDSP_PHASE_OFF, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, QUDSP_CTRL_OFF, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, QUDSP_RATE_OFF, 32'h0);
		check(rd, {26'h0, QUDSP_RATE_RST});
		for (int p = 0; p < 8; p++) begin
			xfer(1'b0, pa(p, QUDSP_PW_TUNE), 32'h0);
			check(rd, QUDSP_TUNE_RST);
			xfer(1'b0, pa(p, QUDSP_PW_PHAMP), 32'h0);
			check(rd, {2'h0, QUDSP_ASF_RST, 2'h0, QUDSP_POW_RST});
			xfer(1'b0, pa(p, QUDSP_PW_GAIN), 32'h0);
			check(rd, {24'h0, QUDSP_GAIN_UNITY});
		end
		xfer(1'b1, 8'h8C, 32'hFFFFFFFF);
		check({31'h0, err}, 32'h1);
		xfer(1'b0, 8'h8C, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		xfer(1'b1, QUDSP_RATE_OFF, 32'h7F);
		xfer(1'b0, QUDSP_RATE_OFF, 32'h0);
		check(rd, 32'h3F);
		repeat (400) @(posedge pclk);
		for (int k = 0; k < 3; k++) begin
			xfer(1'b1, pa(tp[k], QUDSP_PW_TUNE), tw[k]);
			xfer(1'b1, QUDSP_PSEL_OFF, 32'(tp[k]));
			xfer(1'b0, QUDSP_PHASE_OFF, 32'h0);
			p0 = rd;
			c0 = at_cyc;
			xfer(1'b0, QUDSP_PHASE_OFF, 32'h0);
			check(rd - p0, tw[k] * 32'(at_cyc - c0));
		end
		// a second reset parks the accumulator at phase zero for the level checks
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, QUDSP_PHASE_OFF, 32'h0);
		check(rd, 32'h0);
		xfer(1'b1, pa(0, QUDSP_PW_TUNE), 32'h0);
		xfer(1'b1, QUDSP_PSEL_OFF, 32'h0);
		xfer(1'b1, QUDSP_RATE_OFF, 32'h2);
		i_val <= 18'sh10000;
		near(4095);
		for (int k = 0; k < 3; k++) begin
			xfer(1'b1, pa(0, QUDSP_PW_GAIN), 32'(gs[k]));
			near(4095 * gs[k] / 128);
		end
		xfer(1'b1, pa(0, QUDSP_PW_GAIN), 32'h80);
		xfer(1'b1, QUDSP_CTRL_OFF, 32'h4);
		near(2900);
		xfer(1'b1, QUDSP_CTRL_OFF, 32'h0);
		// a factor of one is allowed at this clock rate
		xfer(1'b1, QUDSP_RATE_OFF, 32'h1);
		near(4095);
		xfer(1'b1, QUDSP_CTRL_OFF, 32'h1);
		// gain kept below unity in this mode
		xfer(1'b1, pa(0, QUDSP_PW_GAIN), 32'h40);
		near(2048);
		xfer(1'b1, pa(0, QUDSP_PW_GAIN), 32'h80);
		xfer(1'b1, QUDSP_CTRL_OFF, 32'h0);
		i_val <= 18'sh00000;
		q_val <= 18'sh10000;
		xfer(1'b1, pa(0, QUDSP_PW_PHAMP), {2'h0, 14'h3FFF, 2'h0, 14'h1000});
		near(-4095);
		xfer(1'b1, pa(0, QUDSP_PW_GAIN), 32'h180);
		near(4095);
		xfer(1'b1, pa(0, QUDSP_PW_GAIN), 32'h80);
		xfer(1'b1, QUDSP_CTRL_OFF, 32'h2);
		near(0);
		xfer(1'b1, QUDSP_CTRL_OFF, 32'hA);
		near(4095);
		xfer(1'b1, pa(0, QUDSP_PW_PHAMP), {2'h0, 14'h2000, 2'h0, 14'h1000});
		near(2047);
		xfer(1'b1, QUDSP_CTRL2_OFF, 32'h01000000);
		near(4095);
		xfer(1'b0, QUDSP_STAT_OFF, 32'h0);
		check(32'(rd[17:16]), 32'h2);
		close_out();
	end
endmodule // tb
